// ===== src/bisp_map.svh
`ifndef BISP_MAP_SVH
`define BISP_MAP_SVH

// Command codes received from the host programmer.
`define BISP_CMD_CLK_SEL    8'h11
`define BISP_CMD_RATIO_INQ  8'h22
`define BISP_CMD_FREQ_INQ   8'h23
`define BISP_CMD_BOOT_INQ   8'h24
`define BISP_CMD_USER_INQ   8'h25
`define BISP_CMD_ERASE_INQ  8'h26
`define BISP_CMD_UNIT_INQ   8'h27
`define BISP_CMD_RATE_SEL   8'h3f

// Response, acknowledge and error bytes sent back.
`define BISP_RSP_RATIO      8'h32
`define BISP_RSP_FREQ       8'h33
`define BISP_RSP_BOOT       8'h34
`define BISP_RSP_USER       8'h35
`define BISP_RSP_ERASE      8'h36
`define BISP_RSP_UNIT       8'h37
`define BISP_ACK            8'h06
`define BISP_ERR_CLK        8'h91
`define BISP_ERR_RATE       8'hbf
`define BISP_ERR_CMD        8'h80
`define BISP_EC_SUM         8'h11
`define BISP_EC_MODE        8'h22
`define BISP_EC_RATE        8'h24
`define BISP_EC_FREQ        8'h25
`define BISP_EC_RATIO       8'h26

// Frame geometry.
`define BISP_CLK_SEL_SIZE   8'h01
`define BISP_RATE_SEL_SIZE  8'h07
`define BISP_RATIO_CNT      8'h02
`define BISP_RX_DATA_MAX    8
`define BISP_TX_DEPTH       20
`define BISP_DVEC_BYTES     17

// Supported clock modes.
`define BISP_CLK_MODE_A     8'h00
`define BISP_CLK_MODE_B     8'h01

// Multiplication ratio table: main clock then peripheral clock.
`define BISP_CLK_TYPES      8'h02
`define BISP_MAIN_RATIO_A   8'h04
`define BISP_MAIN_RATIO_B   8'h02
`define BISP_PER_RATIO_A    8'h02
`define BISP_PER_RATIO_B    8'hfe

// Frequency limits in units of 10 kHz.
`define BISP_MAIN_FMIN      16'h07d0
`define BISP_MAIN_FMAX      16'h0fa0
`define BISP_PER_FMIN       16'h03e8
`define BISP_PER_FMAX       16'h07d0
`define BISP_IN_FMIN        16'h03e8
`define BISP_IN_FMAX        16'h07d0

// Bit rate limits in units of 100 bit/s.
`define BISP_RATE_MIN       16'h0018
`define BISP_RATE_MAX       16'h0480

// Memory layout reported to the host.
`define BISP_BOOT_REGIONS   8'h01
`define BISP_BOOT_START     32'h0000_0000
`define BISP_BOOT_LAST      32'h0000_3fff
`define BISP_USER_REGIONS   8'h01
`define BISP_USER_START     32'h0000_0000
`define BISP_USER_LAST      32'h0003_ffff
`define BISP_ERASE_BLOCKS   8'h02
`define BISP_ERASE0_START   32'h0000_0000
`define BISP_ERASE0_LAST    32'h0001_ffff
`define BISP_ERASE1_START   32'h0002_0000
`define BISP_ERASE1_LAST    32'h0003_ffff
`define BISP_PROG_UNIT      16'h0080

`endif

// ===== src/bisp_pkg.sv
package bisp_pkg;

  typedef logic [7:0] bisp_byte_t;

  // Frame receiver states.
  typedef enum logic [3:0] {
    BISP_RX_CMD  = 4'b0001,
    BISP_RX_SIZE = 4'b0010,
    BISP_RX_DATA = 4'b0100,
    BISP_RX_SUM  = 4'b1000
  } bisp_rx_state_t;

  // Selection progress of the protocol.
  typedef enum logic [3:0] {
    BISP_PH_DEV  = 4'b0001,
    BISP_PH_CLK  = 4'b0010,
    BISP_PH_RATE = 4'b0100,
    BISP_PH_SET  = 4'b1000
  } bisp_phase_t;

endpackage

// ===== src/bisp_frm_if.sv
`timescale 1ns/100ps
`default_nettype none

// Carries one received frame from the receiver to the interpreter.
interface bisp_frm_if;
  import bisp_pkg::*;
  logic             frame_done;
  bisp_byte_t       cmd;
  bisp_byte_t       size;
  bisp_byte_t [7:0] data;
  logic             sum_ok;
  logic             busy;

  modport rx  (output frame_done, cmd, size, data, sum_ok, input busy);
  modport dec (input frame_done, cmd, size, data, sum_ok, output busy);
endinterface

`default_nettype wire

// ===== src/bisp_frame_rx.sv
`timescale 1ns/100ps
`default_nettype none
`include "bisp_map.svh"

module bisp_frame_rx
  import bisp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire bisp_byte_t rx_data,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  bisp_frm_if.rx          frm
);

  bisp_rx_state_t state_reg;
  bisp_byte_t     cnt_reg;
  bisp_byte_t     sum_reg;
  logic           take;
  logic           has_body;

  // Bytes are refused while a reply is pending or being sent.
  assign rx_ready = !frm.busy;
  assign take     = rx_valid && rx_ready;
  assign has_body = (rx_data == `BISP_CMD_CLK_SEL) || (rx_data == `BISP_CMD_RATE_SEL);

  // Walks command, size, data and checksum, ending on the size count.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BISP_RX_CMD;
      cnt_reg   <= 8'h00;
    end else if (take) begin
      unique case (state_reg)
        BISP_RX_CMD: begin
          if (has_body) begin
            state_reg <= BISP_RX_SIZE;
          end
        end
        BISP_RX_SIZE: begin
          cnt_reg   <= rx_data; // [RULE20]
          state_reg <= (rx_data == 8'h00) ? BISP_RX_SUM : BISP_RX_DATA; // [RULE24]
        end
        BISP_RX_DATA: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            state_reg <= BISP_RX_SUM;
          end
        end
        BISP_RX_SUM: begin
          state_reg <= BISP_RX_CMD;
        end
      endcase
    end
  end

  // Running sum and captured fields; data beyond the store is summed only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg  <= 8'h00;
      frm.cmd  <= 8'h00;
      frm.size <= 8'h00;
      frm.data <= '0;
    end else if (take) begin
      sum_reg <= sum_reg + rx_data; // [RULE19]
      unique case (state_reg)
        BISP_RX_CMD: begin
          frm.cmd  <= rx_data;
          frm.size <= 8'h00;
          sum_reg  <= rx_data;
        end
        BISP_RX_SIZE: begin
          frm.size <= rx_data;
        end
        BISP_RX_DATA: begin
          if ((frm.size - cnt_reg) < 8'(`BISP_RX_DATA_MAX)) begin
            frm.data[3'(frm.size - cnt_reg)] <= rx_data;
          end
        end
        BISP_RX_SUM: begin
        end
      endcase
    end
  end

  // One-cycle completion pulse with the checksum verdict.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frm.frame_done <= 1'b0;
      frm.sum_ok     <= 1'b0;
    end else begin
      frm.frame_done <= 1'b0;
      if (take && state_reg == BISP_RX_CMD && !has_body) begin
        frm.frame_done <= 1'b1;
        frm.sum_ok     <= 1'b1;
      end else if (take && state_reg == BISP_RX_SUM) begin
        frm.frame_done <= 1'b1;
        frm.sum_ok     <= ((sum_reg + rx_data) == 8'h00); // [RULE19] [RULE24]
      end
    end
  end

endmodule

`default_nettype wire

// ===== src/bisp_cmd_interp.sv
`timescale 1ns/100ps
`default_nettype none
`include "bisp_map.svh"

// Summary of operation
// [RULE1] Clock mode selection frame is 11h, size, one mode byte, checksum.
// [RULE2] A stored supported clock mode is acknowledged with 06h.
// [RULE3] Failed mode selection answers 91h then 11h checksum or 22h mode code.
// [RULE4] Host selects the clock mode only after device selection completes.
// [RULE5] Host selects mode by its reported value, even 00h or 01h.
// [RULE6] Inquiry 22h answers 32h, size, types, per type count and ratios, sum.
// [RULE7] Ratio byte is positive multiplier or negated divisor in two's complement.
// [RULE8] Inquiry 23h answers 33h, size, count, min and max per type, sum.
// [RULE9] Frequencies are megahertz times one hundred in two bytes.
// [RULE10] Inquiry 24h answers 34h, size, region count, start/last pairs, sum.
// [RULE11] A contiguous boot area is reported as one region.
// [RULE12] Inquiry 25h answers 35h, size, region count, start/last pairs, sum.
// [RULE13] Inquiry 26h answers 36h, size, block count, start/last pairs, sum.
// [RULE14] Inquiry 27h answers 37h, size two, two-byte programming unit, sum.
// [RULE15] Bit rate frame is 3Fh, size, rate, input frequency, ratios, sum.
// [RULE16] Bit rate field is bits per second divided by one hundred.
// [RULE17] First ratio is main clock, second is peripheral clock.
// [RULE18] Host sends bit rate selection only after clock mode selection.
// [RULE19] All frame bytes through the checksum sum to zero modulo 256.
// [RULE20] Size counts only data bytes.
// [RULE21] Rejected rate answers BFh and a code; accepted rate answers 06h.
// [RULE22] Unknown or out-of-order commands answer 80h and echo the command.
// [RULE23] Multi-byte fields go most significant byte first.
// [RULE24] The whole frame is received and checked before any action or reply.

module bisp_cmd_interp
  import bisp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       dev_sel_done,
  input  wire bisp_byte_t rx_data,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  output bisp_byte_t      tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output bisp_byte_t      clk_mode,
  output logic            clk_mode_valid,
  output logic [15:0]     bit_rate,
  output logic [15:0]     in_freq,
  output bisp_byte_t      ratio_main,
  output bisp_byte_t      ratio_per,
  output logic            rate_valid,
  output logic            rate_update
);

  bisp_frm_if frm ();

  bisp_frame_rx u_rx (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .rx_ready (rx_ready),
    .frm      (frm)
  );

  bisp_phase_t  phase_reg;
  bisp_byte_t   tx_buf_reg [`BISP_TX_DEPTH];
  logic [4:0]   tx_cnt_reg;
  bisp_byte_t   clk_mode_reg;
  logic         clk_mode_valid_reg;
  logic [15:0]  bit_rate_reg;
  logic [15:0]  in_freq_reg;
  bisp_byte_t   ratio_main_reg;
  bisp_byte_t   ratio_per_reg;
  logic         rate_valid_reg;
  logic         rate_update_reg;

  logic         ld_short;
  logic         ld_frame;
  bisp_byte_t   short0;
  bisp_byte_t   short1;
  logic [4:0]   short_len;
  bisp_byte_t   fr_code;
  logic [135:0] dvec;
  logic [4:0]   dlen;
  logic         act_clk;
  logic         act_rate;
  logic         inq_ok;
  logic         mode_ok;
  logic         ratio_ok;
  logic [15:0]  rx_rate;
  logic [15:0]  rx_freq;
  bisp_byte_t   load_buf [`BISP_TX_DEPTH];
  logic [4:0]   load_len;
  bisp_byte_t   csum;

  // Hold the receiver while a reply waits or is being sent.
  assign frm.busy = (tx_cnt_reg != 5'd0) || frm.frame_done;

  // Decoded fields of the bit rate frame, high byte first.
  assign rx_rate = {frm.data[0], frm.data[1]}; // [RULE16] [RULE23]
  assign rx_freq = {frm.data[2], frm.data[3]}; // [RULE9] [RULE23]

  // Inquiries need device and clock mode selection done first.
  assign inq_ok  = (phase_reg == BISP_PH_RATE) || (phase_reg == BISP_PH_SET);

  // A requested mode must be one of the reported values, 00h included.
  assign mode_ok = (frm.size == `BISP_CLK_SEL_SIZE)
                && ((frm.data[0] == `BISP_CLK_MODE_A)
                 || (frm.data[0] == `BISP_CLK_MODE_B)); // [RULE1] [RULE5]

  // Main and peripheral ratios are matched against their own tables.
  assign ratio_ok = (frm.size == `BISP_RATE_SEL_SIZE)
                 && (frm.data[4] == `BISP_RATIO_CNT)
                 && ((frm.data[5] == `BISP_MAIN_RATIO_A)
                  || (frm.data[5] == `BISP_MAIN_RATIO_B))
                 && ((frm.data[6] == `BISP_PER_RATIO_A)
                  || (frm.data[6] == `BISP_PER_RATIO_B)); // [RULE15] [RULE17] [RULE7]

  // Chooses the reply and the side effects of a completed frame.
  always_comb begin
    ld_short  = 1'b0;
    ld_frame  = 1'b0;
    short0    = `BISP_ERR_CMD;
    short1    = frm.cmd;
    short_len = 5'd2;
    fr_code   = 8'h00;
    dvec      = '0;
    dlen      = 5'd0;
    act_clk   = 1'b0;
    act_rate  = 1'b0;
    if (frm.frame_done) begin // [RULE24]
      case (frm.cmd)
        `BISP_CMD_CLK_SEL: begin
          ld_short = 1'b1;
          if (phase_reg == BISP_PH_DEV) begin
            short0 = `BISP_ERR_CMD; // [RULE22] [RULE4]
          end else if (!frm.sum_ok) begin
            short0 = `BISP_ERR_CLK; // [RULE3]
            short1 = `BISP_EC_SUM;
          end else if (!mode_ok) begin
            short0 = `BISP_ERR_CLK; // [RULE3]
            short1 = `BISP_EC_MODE;
          end else begin
            short0    = `BISP_ACK; // [RULE2]
            short_len = 5'd1;
            act_clk   = 1'b1;
          end
        end
        `BISP_CMD_RATE_SEL: begin
          ld_short = 1'b1;
          short0   = `BISP_ERR_RATE;
          if (!inq_ok) begin
            short0 = `BISP_ERR_CMD; // [RULE22] [RULE18]
          end else if (!frm.sum_ok) begin
            short1 = `BISP_EC_SUM; // [RULE21]
          end else if (rx_rate < `BISP_RATE_MIN || rx_rate > `BISP_RATE_MAX) begin
            short1 = `BISP_EC_RATE; // [RULE21]
          end else if (rx_freq < `BISP_IN_FMIN || rx_freq > `BISP_IN_FMAX) begin
            short1 = `BISP_EC_FREQ; // [RULE21]
          end else if (!ratio_ok) begin
            short1 = `BISP_EC_RATIO; // [RULE21]
          end else begin
            short0    = `BISP_ACK; // [RULE21]
            short_len = 5'd1;
            act_rate  = 1'b1;
          end
        end
        `BISP_CMD_RATIO_INQ: begin
          fr_code = `BISP_RSP_RATIO; // [RULE6]
          dlen    = 5'd7;
          dvec    = {`BISP_CLK_TYPES,
                     `BISP_RATIO_CNT, `BISP_MAIN_RATIO_A, `BISP_MAIN_RATIO_B,
                     `BISP_RATIO_CNT, `BISP_PER_RATIO_A, `BISP_PER_RATIO_B,
                     80'h0}; // [RULE7]
        end
        `BISP_CMD_FREQ_INQ: begin
          fr_code = `BISP_RSP_FREQ; // [RULE8]
          dlen    = 5'd9;
          dvec    = {`BISP_CLK_TYPES, `BISP_MAIN_FMIN, `BISP_MAIN_FMAX,
                     `BISP_PER_FMIN, `BISP_PER_FMAX, 64'h0}; // [RULE9] [RULE23]
        end
        `BISP_CMD_BOOT_INQ: begin
          fr_code = `BISP_RSP_BOOT; // [RULE10]
          dlen    = 5'd9;
          dvec    = {`BISP_BOOT_REGIONS, `BISP_BOOT_START, `BISP_BOOT_LAST,
                     64'h0}; // [RULE11] [RULE23]
        end
        `BISP_CMD_USER_INQ: begin
          fr_code = `BISP_RSP_USER; // [RULE12]
          dlen    = 5'd9;
          dvec    = {`BISP_USER_REGIONS, `BISP_USER_START, `BISP_USER_LAST,
                     64'h0}; // [RULE23]
        end
        `BISP_CMD_ERASE_INQ: begin
          fr_code = `BISP_RSP_ERASE; // [RULE13]
          dlen    = 5'd17;
          dvec    = {`BISP_ERASE_BLOCKS, `BISP_ERASE0_START, `BISP_ERASE0_LAST,
                     `BISP_ERASE1_START, `BISP_ERASE1_LAST}; // [RULE23]
        end
        `BISP_CMD_UNIT_INQ: begin
          fr_code = `BISP_RSP_UNIT; // [RULE14]
          dlen    = 5'd2;
          dvec    = {`BISP_PROG_UNIT, 120'h0}; // [RULE23]
        end
        default: begin
          ld_short = 1'b1; // [RULE22]
        end
      endcase
      if (fr_code != 8'h00) begin
        if (inq_ok) begin
          ld_frame = 1'b1;
        end else begin
          ld_short = 1'b1; // [RULE22]
        end
      end
    end
  end

  // Lays a reply out byte by byte and closes a frame with its checksum.
  always_comb begin
    csum = fr_code + {3'h0, dlen};
    for (int i = 0; i < `BISP_DVEC_BYTES; i++) begin
      csum = csum + dvec[135 - 8 * i -: 8];
    end
    csum = 8'h00 - csum; // [RULE19]
    for (int j = 0; j < `BISP_TX_DEPTH; j++) begin
      load_buf[j] = 8'h00;
    end
    if (ld_frame) begin
      load_buf[0] = fr_code;
      load_buf[1] = {3'h0, dlen}; // [RULE20]
      for (int k = 0; k < `BISP_DVEC_BYTES; k++) begin
        load_buf[k + 2] = dvec[135 - 8 * k -: 8];
      end
      for (int m = 0; m < `BISP_TX_DEPTH; m++) begin
        if (5'(m) == dlen + 5'd2) begin
          load_buf[m] = csum;
        end
      end
      load_len = dlen + 5'd3;
    end else begin
      load_buf[0] = short0;
      load_buf[1] = short1;
      load_len    = short_len;
    end
  end

  // Reply shifter; the head byte is the transmit data.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_reg <= 5'd0;
      for (int n = 0; n < `BISP_TX_DEPTH; n++) begin
        tx_buf_reg[n] <= 8'h00;
      end
    end else if (ld_short || ld_frame) begin
      tx_cnt_reg <= load_len;
      tx_buf_reg <= load_buf;
    end else if (tx_valid && tx_ready) begin
      tx_cnt_reg <= tx_cnt_reg - 5'd1;
      for (int n = 0; n < `BISP_TX_DEPTH - 1; n++) begin
        tx_buf_reg[n] <= tx_buf_reg[n + 1];
      end
      tx_buf_reg[`BISP_TX_DEPTH - 1] <= 8'h00;
    end
  end

  assign tx_valid = (tx_cnt_reg != 5'd0);
  assign tx_data  = tx_buf_reg[0];

  // Selection progress; repeated selections keep the latest value.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= BISP_PH_DEV;
    end else begin
      unique case (phase_reg)
        BISP_PH_DEV: begin
          if (dev_sel_done) begin
            phase_reg <= BISP_PH_CLK; // [RULE4]
          end
        end
        BISP_PH_CLK: begin
          if (act_clk) begin
            phase_reg <= BISP_PH_RATE; // [RULE18]
          end
        end
        BISP_PH_RATE: begin
          if (act_rate) begin
            phase_reg <= BISP_PH_SET;
          end
        end
        BISP_PH_SET: begin
        end
      endcase
    end
  end

  // Stored clock mode.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_mode_reg       <= 8'h00;
      clk_mode_valid_reg <= 1'b0;
    end else if (act_clk) begin
      clk_mode_reg       <= frm.data[0]; // [RULE2]
      clk_mode_valid_reg <= 1'b1;
    end
  end

  // Stored bit rate settings with a one-cycle update pulse.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_rate_reg    <= 16'h0000;
      in_freq_reg     <= 16'h0000;
      ratio_main_reg  <= 8'h00;
      ratio_per_reg   <= 8'h00;
      rate_valid_reg  <= 1'b0;
      rate_update_reg <= 1'b0;
    end else begin
      rate_update_reg <= act_rate;
      if (act_rate) begin
        bit_rate_reg   <= rx_rate; // [RULE16]
        in_freq_reg    <= rx_freq;
        ratio_main_reg <= frm.data[5]; // [RULE17]
        ratio_per_reg  <= frm.data[6]; // [RULE17]
        rate_valid_reg <= 1'b1;
      end
    end
  end

  assign clk_mode       = clk_mode_reg;
  assign clk_mode_valid = clk_mode_valid_reg;
  assign bit_rate       = bit_rate_reg;
  assign in_freq        = in_freq_reg;
  assign ratio_main     = ratio_main_reg;
  assign ratio_per      = ratio_per_reg;
  assign rate_valid     = rate_valid_reg;
  assign rate_update    = rate_update_reg;

endmodule

`default_nettype wire

// ===== testbench/bisp_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "bisp_map.svh"

// Watches reply handshakes and stored selections at the interpreter ports.
module bisp_chk
  import bisp_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        dev_sel_done,
  input wire bisp_byte_t  rx_data,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire bisp_byte_t  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire bisp_byte_t  clk_mode,
  input wire logic        clk_mode_valid,
  input wire logic [15:0] bit_rate,
  input wire logic [15:0] in_freq,
  input wire bisp_byte_t  ratio_main,
  input wire bisp_byte_t  ratio_per,
  input wire logic        rate_valid,
  input wire logic        rate_update
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // No byte is taken while a reply is pending, and every frame is answered.
  reply_refuse_a: assert property (tx_valid |-> !rx_ready)
    else $error("byte taken while reply pending");
  reply_start_a: assert property ($fell(rx_ready) |-> ##[1:3] tx_valid)
    else $error("no reply after frame");
  reply_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("reply byte lost in stall");
  // Update pulse lasts one cycle; stored mode, ratios and bit rate hold only accepted, supported values.
  update_pulse_a: assert property (rate_update |=> !rate_update)
    else $error("rate update too long");
  mode_supported_a: assert property (clk_mode_valid |->
    clk_mode inside {`BISP_CLK_MODE_A, `BISP_CLK_MODE_B})
    else $error("unsupported clock mode stored");
  rate_fields_a: assert property ($changed(bit_rate) || $changed(in_freq)
    || $changed(ratio_main) || $changed(ratio_per) |-> rate_update)
    else $error("rate fields changed alone");
  ratio_table_a: assert property (rate_valid |-> ratio_main inside {8'h04, 8'h02}
    && ratio_per inside {8'h02, 8'hfe})
    else $error("ratio outside table stored");
  rate_range_a: assert property (rate_valid |-> bit_rate >= `BISP_RATE_MIN
    && bit_rate <= `BISP_RATE_MAX)
    else $error("bit rate out of range");
  // Main scenarios reached.
  cover property (rate_update);
  cover property (tx_valid && !tx_ready);
  cover property ($rose(clk_mode_valid));
endmodule

bind bisp_cmd_interp bisp_chk bisp_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .dev_sel_done(dev_sel_done), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .clk_mode(clk_mode),
  .clk_mode_valid(clk_mode_valid), .bit_rate(bit_rate), .in_freq(in_freq),
  .ratio_main(ratio_main), .ratio_per(ratio_per), .rate_valid(rate_valid),
  .rate_update(rate_update));

`default_nettype wire

// ===== testbench/bisp_host_mdl.sv
`timescale 1ns/100ps
`default_nettype none

// Host programmer: offers command bytes and drains reply bytes, fast or slow.
module bisp_host_mdl
  import bisp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  output bisp_byte_t      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire bisp_byte_t tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic       slow = 1'b0;
  logic [1:0] pace_reg;
  int         hang_cnt = 0;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
  end

  // In slow mode the sink takes one byte in three cycles.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_reg <= 2'h0;
    end else begin
      pace_reg <= (pace_reg == 2'h2) ? 2'h0 : pace_reg + 2'h1;
    end
  end
  assign tx_ready = slow ? (pace_reg == 2'h2) : 1'b1;

  // Holds a byte until the device takes it.
  task automatic put(input bisp_byte_t b);
    int n;
    n = 0;
    rx_data  <= b;
    rx_valid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rx_ready !== 1'b1 && n < 400);
    if (n >= 400) hang_cnt++;
  endtask

  // Releases the line; data shows the inverted last byte.
  task automatic drop();
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask

  // Waits for a reply byte handed over at a rising edge.
  task automatic take(output bisp_byte_t b);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 400);
    if (n >= 400) hang_cnt++;
    b = tx_data;
  endtask
endmodule

`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "bisp_map.svh"

module tb;
  import bisp_pkg::*;
  typedef bisp_byte_t bisp_bq_t[$];

  logic        ref_clk;
  logic        rst_n;
  logic        dev_sel_done;
  bisp_byte_t  rx_data;
  logic        rx_valid;
  logic        rx_ready;
  bisp_byte_t  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  bisp_byte_t  clk_mode;
  logic        clk_mode_valid;
  logic [15:0] bit_rate;
  logic [15:0] in_freq;
  bisp_byte_t  ratio_main;
  bisp_byte_t  ratio_per;
  logic        rate_valid;
  logic        rate_update;
  int          error_cnt = 0;
  int          check_count = 0;

  bisp_cmd_interp bisp_cmd_interp_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .dev_sel_done(dev_sel_done), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .clk_mode(clk_mode), .clk_mode_valid(clk_mode_valid), .bit_rate(bit_rate),
    .in_freq(in_freq), .ratio_main(ratio_main), .ratio_per(ratio_per),
    .rate_valid(rate_valid), .rate_update(rate_update));
  bisp_host_mdl bisp_host_mdl_i (.ref_clk(ref_clk), .rst_n(rst_n), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));

  // Appends the byte that brings the frame sum to zero.
  function automatic bisp_bq_t seal(input bisp_bq_t q);
    bisp_byte_t s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    q.push_back(8'h00 - s);
    return q;
  endfunction

  // Appends a field of n bytes, most significant first.
  function automatic bisp_bq_t app(input bisp_bq_t q, input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) q.push_back(v[8*i +: 8]);
    return q;
  endfunction

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // Sends a frame and checks the whole reply and its end.
  task automatic xfer(input bisp_bq_t f, input bisp_bq_t e, input string nm);
    bisp_byte_t b;
    foreach (f[i]) bisp_host_mdl_i.put(f[i]);
    bisp_host_mdl_i.drop();
    foreach (e[i]) begin
      bisp_host_mdl_i.take(b);
      chk(b === e[i], $sformatf("%s byte %0d got %h", nm, i, b));
    end
    #1;
    chk(tx_valid === 1'b0 && rx_ready === 1'b1, {nm, " reply too long"});
    @(posedge ref_clk);
  endtask

  task automatic t_order();
    xfer(seal('{8'h11, 8'h01, 8'h00}), '{8'h80, 8'h11}, "mode early");
    xfer('{8'h22}, '{8'h80, 8'h22}, "inquiry early");
    xfer('{8'h55}, '{8'h80, 8'h55}, "unknown");
    chk(clk_mode_valid === 1'b0, "mode stored early");
    $display("test order done");
  endtask
  task automatic t_clk();
    bisp_bq_t f;
    dev_sel_done <= 1'b1;
    @(posedge ref_clk);
    f = seal('{8'h11, 8'h01, 8'h01});
    f[3] = f[3] + 8'h01;
    xfer(f, '{8'h91, 8'h11}, "mode sum");
    xfer(seal('{8'h11, 8'h01, 8'h02}), '{8'h91, 8'h22}, "mode bad");
    chk(clk_mode_valid === 1'b0, "bad mode stored");
    xfer(seal('{8'h3f, 8'h00}), '{8'h80, 8'h3f}, "rate early");
    xfer(seal('{8'h11, 8'h01, 8'h01}), '{8'h06}, "mode 01");
    chk(clk_mode === 8'h01 && clk_mode_valid === 1'b1, "mode 01 stored");
    xfer(seal('{8'h11, 8'h01, 8'h00}), '{8'h06}, "mode 00");
    chk(clk_mode === 8'h00 && clk_mode_valid === 1'b1, "mode 00 stored");
    $display("test clock mode done");
  endtask
  task automatic t_inq();
    bisp_bq_t e;
    bisp_host_mdl_i.slow <= 1'b1;
    e = '{8'h32, 8'h07, 8'h02, 8'h02, 8'h04, 8'h02, 8'h02, 8'h02, 8'hfe};
    xfer('{8'h22}, seal(e), "ratio");
    bisp_host_mdl_i.slow <= 1'b0;
    e = app(app('{8'h33, 8'h09, 8'h02}, `BISP_MAIN_FMIN, 2), `BISP_MAIN_FMAX, 2);
    xfer('{8'h23}, seal(app(app(e, `BISP_PER_FMIN, 2), `BISP_PER_FMAX, 2)), "freq");
    e = app(app('{8'h34, 8'h09, 8'h01}, `BISP_BOOT_START, 4), `BISP_BOOT_LAST, 4);
    xfer('{8'h24}, seal(e), "boot");
    e = app(app('{8'h35, 8'h09, 8'h01}, `BISP_USER_START, 4), `BISP_USER_LAST, 4);
    xfer('{8'h25}, seal(e), "user");
    e = app(app('{8'h36, 8'h11, 8'h02}, `BISP_ERASE0_START, 4), `BISP_ERASE0_LAST, 4);
    e = app(app(e, `BISP_ERASE1_START, 4), `BISP_ERASE1_LAST, 4);
    xfer('{8'h26}, seal(e), "erase");
    xfer('{8'h27}, seal(app('{8'h37, 8'h02}, `BISP_PROG_UNIT, 2)), "unit");
    $display("test inquiries done");
  endtask
  task automatic t_rate();
    bisp_bq_t f, g;
    f = '{8'h3f, 8'h07, 8'h00, 8'hc0, 8'h07, 8'hd0, 8'h02, 8'h04, 8'hfe};
    xfer(seal(f), '{8'h06}, "rate ok");
    chk(bit_rate === 16'h00c0 && in_freq === 16'h07d0, "rate fields");
    chk(ratio_main === 8'h04 && ratio_per === 8'hfe && rate_valid === 1'b1, "ratios");
    g = seal(f);
    g[9] = g[9] + 8'h01;
    xfer(g, '{8'hbf, 8'h11}, "rate sum");
    g = f;
    g[3] = 8'h17;
    xfer(seal(g), '{8'hbf, 8'h24}, "rate low");
    g = f;
    g[5] = 8'hd1;
    xfer(seal(g), '{8'hbf, 8'h25}, "in freq high");
    g = f;
    g[8] = 8'h03;
    xfer(seal(g), '{8'hbf, 8'h26}, "ratio bad");
    chk(bit_rate === 16'h00c0 && ratio_per === 8'hfe, "rate kept");
    $display("test bit rate done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Ends a hung run well past the expected length.
  initial begin
    #100000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  // Resets, then runs the scenarios in protocol order.
  initial begin
    rst_n        = 1'b0;
    dev_sel_done = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_order();
    t_clk();
    t_inq();
    t_rate();
    chk(bisp_host_mdl_i.hang_cnt == 0, "handshake hang");
    close_out();
  end
endmodule

`default_nettype wire
